//--- design/oscillator_clock_select.sv
// Clock control: internal oscillator run/settle, main/peripheral/CPU clock selection,
// CPU divider, clock status flags and subsystem clock pin mode, reached over APB.
// Assumes a 100 MHz clk, an asynchronous oscillator ready level, and a STOP pulse from the CPU.
//
// Operation
// RULE1: clearing the halt bit starts the internal oscillator.
// RULE2: settled bit goes to 1 after the oscillator stabilises; software polls it.
// RULE3: after reset the internal oscillator runs and clocks the CPU.
// RULE4: software may skip the settle wait when accuracy is not needed.
// RULE5: source select 0 gives internal clock to both; 1 with pick 0 feeds peripherals.
// RULE6: CPU source select 0 feeds the CPU from the divided main clock.
// RULE7: divider codes 0..4 divide by 1,2,4,8,16; reset code divides by 2.
// RULE8: STOP instruction enters STOP mode and halts the internal oscillator.
// RULE9: setting the halt bit stops the internal oscillator.
// RULE10: two status flags report internal, high-speed or subsystem CPU clock.
// RULE11: software halts the oscillator only when the CPU is off it.
// RULE12: software sets wake settle time before STOP when on the crystal clock.
// RULE13: software stops unsuitable peripherals before STOP.
// RULE14: subsystem external select 0 puts the pins in crystal mode.
// RULE15: external select 1 puts pins in external-clock mode, second pin unused.
// RULE16: software times subsystem crystal settling with a timer.
// RULE17: software leaves subsystem pin bits alone while the subsystem clock runs.
// RULE18: software avoids pin-clocked peripherals with high-speed clocks stopped or in STOP.
// RULE19: select and pick both 1 give the high-speed clock to main and peripherals.
// RULE20: CPU source select 1 feeds the CPU from subsystem clock divided by two.
// RULE21: clock switches are glitch free; status follows the applied switch.
// RULE22: settled bit clears whenever the internal oscillator is stopped.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "osc_clock_select_defines.svh"

module oscillator_clock_select #(
    parameter int SETTLE_CYCLES = `HS_SETTLE_CYCLES,
    parameter int GAP_CYCLES    = `SWITCH_GAP_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Standby control
    input  wire logic        stop_exec,
    input  wire logic        stop_wake,
    output logic             stop_mode,
    // Internal oscillator
    input  wire logic        hs_osc_ready,
    output logic             hs_osc_run,
    // Clock selection results
    output logic             cpu_clk_tick,
    output logic [1:0]       cpu_src_applied,
    output logic             periph_on_hs,
    // Subsystem clock pins
    output logic             sub_osc_pin_a_osc_en,
    output logic             sub_ext_clock_pin_en,
    output logic             sub_osc_pin_b_osc_en,
    output logic             sub_osc_pin_b_oe
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_s1_q;
    logic rst_n_q;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic       hs_osc_halt_q;
    logic       main_source_select_q;
    logic       main_clock_pick_q;
    logic [2:0] cpu_div_q;
    logic       cpu_source_select_q;
    logic       sub_clock_out_enable_q;
    logic       sub_external_select_q;
    logic       sub_pins_enable_q;
    logic       stop_mode_q;
    logic       hs_osc_settled_q;

    clk_switch_if sw_bus ();

    // Divider code legality; prohibited codes are not stored
    function automatic logic div_code_ok(input logic [2:0] code);
        div_code_ok = (code <= 3'h4);
    endfunction

    // Low-bit mask whose all-zero count marks one divided clock period
    function automatic logic [3:0] div_mask(input logic [2:0] code);
        unique case (code)
            3'h0:    div_mask = 4'h0;
            3'h1:    div_mask = 4'h1;
            3'h2:    div_mask = 4'h3;
            3'h3:    div_mask = 4'h7;
            default: div_mask = 4'hF;
        endcase
    endfunction

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire logic        apb_access = psel && penable;
    wire logic        apb_fire   = apb_access && pready;
    wire logic        wr_fire    = apb_fire && pwrite;
    wire logic        hit_osc    = (paddr == `OFF_INTERNAL_OSC_CTL);
    wire logic        hit_main   = (paddr == `OFF_MAIN_CLOCK_MODE_REG);
    wire logic        hit_cpu    = (paddr == `OFF_CPU_CLOCK_CTL_REG);
    wire logic        hit_sub    = (paddr == `OFF_SUB_PIN_CTL_REG);
    wire logic        hit_any    = hit_osc || hit_main || hit_cpu || hit_sub;
    wire logic        flag_main  = sw_bus.app_cpu[0];
    wire logic        flag_sub   = sw_bus.app_cpu[1];
    wire logic [2:0]  new_div    = pwdata[`MSB_CPU_DIV:`LSB_CPU_DIV];

    logic [31:0] rd_word;

    // Read word selection; reserved bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_osc) begin
            rd_word[`BIT_HS_OSC_HALT]    = hs_osc_halt_q;
            rd_word[`BIT_HS_OSC_SETTLED] = hs_osc_settled_q;        // RULE2
        end
        if (hit_main) begin
            rd_word[`BIT_MAIN_CLOCK_PICK]    = main_clock_pick_q;
            rd_word[`BIT_CPU_ON_MAIN_FLAG]   = flag_main;           // RULE10
            rd_word[`BIT_MAIN_SOURCE_SELECT] = main_source_select_q;
        end
        if (hit_cpu) begin
            rd_word[`MSB_CPU_DIV:`LSB_CPU_DIV] = cpu_div_q;
            rd_word[`BIT_CPU_SOURCE_SELECT]    = cpu_source_select_q;
            rd_word[`BIT_CPU_ON_SUB_FLAG]      = flag_sub;          // RULE10
        end
        if (hit_sub) begin
            rd_word[`BIT_SUB_CLOCK_OUT_ENABLE] = sub_clock_out_enable_q;
            rd_word[`BIT_SUB_EXTERNAL_SELECT]  = sub_external_select_q;
            rd_word[`BIT_SUB_PINS_ENABLE]      = sub_pins_enable_q;
        end
    end

    // Answer one cycle into the access phase; data and error ride with pready
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_access && !pready;
            prdata  <= (apb_access && !pready && !pwrite) ? rd_word : 32'h0000_0000;
            pslverr <= apb_access && !pready && !hit_any;
        end
    end

    // Register writes take effect at the edge that completes the transfer
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hs_osc_halt_q          <= `RST_HS_OSC_HALT;             // RULE3
            main_source_select_q   <= 1'(`RST_MAIN_SELECTS >> 1);
            main_clock_pick_q      <= 1'b0;
            cpu_div_q              <= `RST_CPU_DIV;                 // RULE7
            cpu_source_select_q    <= `RST_CPU_SOURCE;              // RULE3
            sub_clock_out_enable_q <= 1'b0;
            sub_external_select_q  <= 1'b0;
            sub_pins_enable_q      <= 1'b0;
        end else if (wr_fire) begin
            if (hit_osc) begin
                hs_osc_halt_q <= pwdata[`BIT_HS_OSC_HALT];          // RULE1 RULE9
            end
            if (hit_main) begin
                main_clock_pick_q    <= pwdata[`BIT_MAIN_CLOCK_PICK];
                main_source_select_q <= pwdata[`BIT_MAIN_SOURCE_SELECT];
            end
            if (hit_cpu) begin
                cpu_source_select_q <= pwdata[`BIT_CPU_SOURCE_SELECT];
                if (div_code_ok(new_div)) begin
                    cpu_div_q <= new_div;                           // RULE7
                end
            end
            if (hit_sub) begin
                sub_clock_out_enable_q <= pwdata[`BIT_SUB_CLOCK_OUT_ENABLE];
                sub_external_select_q  <= pwdata[`BIT_SUB_EXTERNAL_SELECT];
                sub_pins_enable_q      <= pwdata[`BIT_SUB_PINS_ENABLE];
            end
        end
    end

    // ****************************************************************
    // STOP mode and internal oscillator
    // ****************************************************************
    logic        rdy_s1_q;
    logic        rdy_s2_q;
    logic        rdy_s3_q;
    logic        rdy_q;
    logic        run_q;
    logic [15:0] settle_cnt_q;

    localparam logic [15:0] SETTLE = 16'(SETTLE_CYCLES);

    // STOP instruction sets the mode; wake clears it, wake winning a tie
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stop_mode_q <= 1'b0;
        end else if (stop_wake) begin
            stop_mode_q <= 1'b0;
        end else if (stop_exec) begin
            stop_mode_q <= 1'b1;                                    // RULE8
        end
    end

    // Oscillator runs unless halted by software or by STOP mode
    wire logic run_d = !hs_osc_halt_q && !stop_mode_q;              // RULE1 RULE8 RULE9

    // Ready level from the oscillator: three stages, taken when the last two agree
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
            rdy_s3_q <= 1'b0;
            rdy_q    <= 1'b0;
        end else begin
            rdy_s1_q <= hs_osc_ready;
            rdy_s2_q <= rdy_s1_q;
            rdy_s3_q <= rdy_s2_q;
            rdy_q    <= (rdy_s2_q == rdy_s3_q) ? rdy_s3_q : rdy_q;
        end
    end

    // Settle count runs while the oscillator runs and reports ready
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            run_q            <= 1'b0;
            settle_cnt_q     <= 16'h0000;
            hs_osc_settled_q <= 1'b0;
        end else begin
            run_q <= run_d;
            if (!run_d || !rdy_q) begin
                settle_cnt_q     <= 16'h0000;
                hs_osc_settled_q <= 1'b0;                           // RULE22
            end else if (settle_cnt_q >= SETTLE) begin
                hs_osc_settled_q <= 1'b1;                           // RULE2
            end else begin
                settle_cnt_q <= settle_cnt_q + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // Clock selection
    // ****************************************************************
    wire logic main_is_hs = main_source_select_q && main_clock_pick_q;   // RULE5 RULE19

    assign sw_bus.req_periph_hs = main_source_select_q;                  // RULE5 RULE19
    assign sw_bus.req_cpu = cpu_source_select_q ? osc_clock_pkg::SRC_SUB     // RULE20
                          : main_is_hs          ? osc_clock_pkg::SRC_HS      // RULE6
                          :                       osc_clock_pkg::SRC_INTERNAL;

    clock_switch #(
        .GAP_CYCLES (GAP_CYCLES)
    ) u_switch (
        .clk   (clk),
        .rst_n (rst_n_q),
        .sw_if (sw_bus)
    );

    // ****************************************************************
    // CPU divider and outputs
    // ****************************************************************
    logic [3:0] div_cnt_q;

    wire logic [3:0] mask = flag_sub ? 4'h1 : div_mask(cpu_div_q);     // RULE6 RULE20

    // Divided CPU clock as a one-cycle tick, held off while the switch gates
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_cnt_q    <= 4'h0;
            cpu_clk_tick <= 1'b0;
        end else begin
            div_cnt_q    <= div_cnt_q + 4'h1;
            cpu_clk_tick <= sw_bus.gate_open && ((div_cnt_q & mask) == 4'h0);  // RULE7 RULE21
        end
    end

    // Registered copies of selection and pin mode
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stop_mode            <= 1'b0;
            hs_osc_run           <= 1'b0;
            cpu_src_applied      <= 2'h0;
            periph_on_hs         <= 1'b0;
            sub_osc_pin_a_osc_en <= 1'b0;
            sub_ext_clock_pin_en <= 1'b0;
            sub_osc_pin_b_osc_en <= 1'b0;
            sub_osc_pin_b_oe     <= 1'b0;
        end else begin
            stop_mode            <= stop_mode_q;
            hs_osc_run           <= run_q;                                   // RULE3
            cpu_src_applied      <= sw_bus.app_cpu;                          // RULE21
            periph_on_hs         <= sw_bus.app_periph_hs;
            sub_osc_pin_a_osc_en <= sub_pins_enable_q && !sub_external_select_q;  // RULE14
            sub_osc_pin_b_osc_en <= sub_pins_enable_q && !sub_external_select_q;  // RULE14
            sub_ext_clock_pin_en <= sub_pins_enable_q && sub_external_select_q;   // RULE15
            sub_osc_pin_b_oe     <= 1'b0;                                    // RULE15
        end
    end

endmodule // oscillator_clock_select

//--- design/osc_clock_select_defines.svh
// Offsets, field positions, reset values and timing counts of the clock-select block.
// Assumes a 100 MHz system clock and 32-bit APB word addressing.
`ifndef OSC_CLOCK_SELECT_DEFINES_SVH
`define OSC_CLOCK_SELECT_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFF_INTERNAL_OSC_CTL    12'h000
`define OFF_MAIN_CLOCK_MODE_REG 12'h004
`define OFF_CPU_CLOCK_CTL_REG   12'h008
`define OFF_SUB_PIN_CTL_REG     12'h00C

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_HS_OSC_HALT          0
`define BIT_HS_OSC_SETTLED       7
`define BIT_MAIN_CLOCK_PICK      0
`define BIT_CPU_ON_MAIN_FLAG     1
`define BIT_MAIN_SOURCE_SELECT   2
`define LSB_CPU_DIV              0
`define MSB_CPU_DIV              2
`define BIT_CPU_SOURCE_SELECT    4
`define BIT_CPU_ON_SUB_FLAG      5
`define BIT_SUB_CLOCK_OUT_ENABLE 0
`define BIT_SUB_EXTERNAL_SELECT  1
`define BIT_SUB_PINS_ENABLE      2

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_HS_OSC_HALT   1'b0
`define RST_CPU_DIV       3'h1
`define RST_CPU_SOURCE    1'b0
`define RST_MAIN_SELECTS  2'h0
`define RST_SUB_PIN_CTL   3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS     10
`define HS_SETTLE_NS      10000
`define HS_SETTLE_CYCLES  ((`HS_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SWITCH_GAP_NS     40
`define SWITCH_GAP_CYCLES ((`SWITCH_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- design/osc_clock_pkg.sv
// Types shared by the clock-select block and its switch sequencer.
// Assumes nothing of its surroundings.
package osc_clock_pkg;

    // CPU clock source codes; the two bits equal the sub/main status flags
    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'h0,
        SRC_HS       = 2'h1,
        SRC_SUB      = 2'h2
    } cpu_src_e;

    // Switch sequencer states, Gray along the switch path
    typedef enum logic [1:0] {
        SW_IDLE     = 2'h0,
        SW_GATE_OFF = 2'h1,
        SW_RESEL    = 2'h3,
        SW_GATE_ON  = 2'h2
    } sw_state_e;

endpackage

//--- design/clk_switch_if.sv
// Request and applied clock selections between the control logic and the switch sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps

interface clk_switch_if;
    osc_clock_pkg::cpu_src_e req_cpu;
    logic                    req_periph_hs;
    osc_clock_pkg::cpu_src_e app_cpu;
    logic                    app_periph_hs;
    logic                    gate_open;

    modport ctl (output req_cpu, output req_periph_hs, input app_cpu, input app_periph_hs, input gate_open);
    modport sw  (input req_cpu, input req_periph_hs, output app_cpu, output app_periph_hs, output gate_open);
endinterface

//--- design/clock_switch.sv
// Glitch-free switch sequencer: gates the clock off, changes selection, gates it on again.
// Assumes a synchronised active-low reset on the system clock.
`timescale 1ns/1ps
`include "osc_clock_select_defines.svh"

module clock_switch #(
    parameter int GAP_CYCLES = `SWITCH_GAP_CYCLES
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    clk_switch_if.sw    sw_if
);
    localparam logic [7:0] GAP = 8'(GAP_CYCLES);

    osc_clock_pkg::sw_state_e state_q;
    osc_clock_pkg::cpu_src_e  app_cpu_q;
    logic                     app_periph_q;
    logic                     gate_q;
    logic [7:0]               cnt_q;

    // ****************************************************************
    // Change detection
    // ****************************************************************
    wire logic differs   = (sw_if.req_cpu != app_cpu_q) || (sw_if.req_periph_hs != app_periph_q);
    wire logic cnt_done  = (cnt_q == 8'h00);

    // Sequencer: selection only changes while the clock is gated off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q      <= osc_clock_pkg::SW_IDLE;
            app_cpu_q    <= osc_clock_pkg::SRC_INTERNAL;
            app_periph_q <= 1'b0;
            gate_q       <= 1'b1;
            cnt_q        <= 8'h00;
        end else begin
            unique case (state_q)
                osc_clock_pkg::SW_IDLE: begin
                    if (differs) begin
                        gate_q  <= 1'b0;                           // RULE21
                        cnt_q   <= GAP;
                        state_q <= osc_clock_pkg::SW_GATE_OFF;
                    end
                end
                osc_clock_pkg::SW_GATE_OFF: begin
                    cnt_q <= cnt_done ? 8'h00 : cnt_q - 8'h01;
                    if (cnt_done) begin
                        state_q <= osc_clock_pkg::SW_RESEL;
                    end
                end
                osc_clock_pkg::SW_RESEL: begin
                    app_cpu_q    <= sw_if.req_cpu;                // RULE21
                    app_periph_q <= sw_if.req_periph_hs;
                    cnt_q        <= GAP;
                    state_q      <= osc_clock_pkg::SW_GATE_ON;
                end
                osc_clock_pkg::SW_GATE_ON: begin
                    cnt_q <= cnt_done ? 8'h00 : cnt_q - 8'h01;
                    if (cnt_done) begin
                        gate_q  <= 1'b1;
                        state_q <= osc_clock_pkg::SW_IDLE;
                    end
                end
            endcase
        end
    end

    assign sw_if.app_cpu       = app_cpu_q;
    assign sw_if.app_periph_hs = app_periph_q;
    assign sw_if.gate_open     = gate_q;
endmodule // clock_switch

//--- verif/oscillator_clock_select_chk.sv
// Port checks of the clock-select top module.
// Assumes one clock domain; bound in below.
`timescale 1ns/1ps

module oscillator_clock_select_chk (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       stop_exec,
    input wire logic       stop_wake,
    input wire logic       stop_mode,
    input wire logic       hs_osc_run,
    input wire logic       cpu_clk_tick,
    input wire logic [1:0] cpu_src_applied,
    input wire logic       sub_osc_pin_a_osc_en,
    input wire logic       sub_ext_clock_pin_en,
    input wire logic       sub_osc_pin_b_osc_en,
    input wire logic       sub_osc_pin_b_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ****************************************************************
    // Sequences
    // ****************************************************************
    // Tick held low two cycles
    sequence seq_gate_shut;
        !cpu_clk_tick ##1 !cpu_clk_tick;
    endsequence
    // One wait state
    sequence seq_one_wait;
        !pready ##1 pready;
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    chk_apb_wait: assert property (psel && $rose(penable) |-> seq_one_wait)
        else $error("wait state wrong");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("stray pslverr");
    chk_stop_enter: assert property (stop_exec && !stop_wake |-> ##[1:3] stop_mode)
        else $error("no stop mode");
    chk_stop_halt: assert property (stop_exec && !stop_wake |-> ##[1:4] !hs_osc_run)
        else $error("osc runs in stop");
    chk_switch_gated: assert property ($changed(cpu_src_applied) |-> seq_gate_shut)
        else $error("tick during switch");
    chk_status_code: assert property (cpu_src_applied != 2'h3)
        else $error("bad status code");
    chk_sub_tick: assert property (cpu_clk_tick && cpu_src_applied == 2'h2 |=> !cpu_clk_tick)
        else $error("sub tick not halved");
    chk_pin_b_idle: assert property (!sub_osc_pin_b_oe)
        else $error("second pin driven");
    chk_pin_modes: assert property ((sub_osc_pin_a_osc_en == sub_osc_pin_b_osc_en) &&
        !(sub_osc_pin_a_osc_en && sub_ext_clock_pin_en))
        else $error("pin modes clash");
endmodule // oscillator_clock_select_chk

bind oscillator_clock_select oscillator_clock_select_chk u_chk (
    .clk,
    .reset_n,
    .psel,
    .penable,
    .pready,
    .pslverr,
    .stop_exec,
    .stop_wake,
    .stop_mode,
    .hs_osc_run,
    .cpu_clk_tick,
    .cpu_src_applied,
    .sub_osc_pin_a_osc_en,
    .sub_ext_clock_pin_en,
    .sub_osc_pin_b_osc_en,
    .sub_osc_pin_b_oe
);

//--- verif/oscillator_clock_select_tb_top.sv
// Directed bench for the clock-select block over APB.
// Assumes short settle and gap counts.
`timescale 1ns/1ps

module oscillator_clock_select_tb_top;
    logic        clk, reset_n, psel, penable, pwrite, stop_exec, stop_wake, osc_ready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, e, stop_mode, osc_run, tick, periph_hs, pin_a, pin_ext, pin_b, pin_b_oe;
    logic [1:0]  src;
    int          failures = 0, n_tests = 0;
    logic [31:0] pin_val [5] = '{32'h4, 32'h5, 32'h6, 32'h7, 32'h2};
    logic [2:0]  pin_exp [5] = '{3'h5, 3'h5, 3'h2, 3'h2, 3'h0};

    oscillator_clock_select #(.SETTLE_CYCLES(4), .GAP_CYCLES(1)) u_dut (
        .clk,
        .reset_n,
        .psel,
        .penable,
        .pwrite,
        .paddr,
        .pwdata,
        .prdata,
        .pready,
        .pslverr,
        .stop_exec,
        .stop_wake,
        .stop_mode,
        .hs_osc_ready        (osc_ready),
        .hs_osc_run          (osc_run),
        .cpu_clk_tick        (tick),
        .cpu_src_applied     (src),
        .periph_on_hs        (periph_hs),
        .sub_osc_pin_a_osc_en(pin_a),
        .sub_ext_clock_pin_en(pin_ext),
        .sub_osc_pin_b_osc_en(pin_b),
        .sub_osc_pin_b_oe    (pin_b_oe)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One APB transfer, held until pready is high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(r, exp, "read data");
        check(e, 32'h0, "read error");
    endtask
    // Cycles between two CPU ticks
    task automatic period(input int exp);
        int n = 0;
        while (tick !== 1'b1) @(posedge clk);
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1);
        check(n, exp, "tick period");
    endtask
    task automatic tally_and_finish;
        $display("compares %0d fails %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and tests
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Oscillator reports ready a cycle after it is enabled
    always @(posedge clk) osc_ready <= osc_run;
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
    initial begin
        {reset_n, psel, penable, pwrite, stop_exec, stop_wake, paddr, pwdata} = '0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (20) @(posedge clk);
        check(osc_run, 32'h1, "run after reset");
        check(src, 32'h0, "source at reset");
        rd(12'h000, 32'h80);
        rd(12'h004, 32'h0);
        rd(12'h008, 32'h1);
        period(2);
        for (int c = 0; c < 5; c++) begin
            apb(1'b1, 12'h008, c);
            repeat (10) @(posedge clk);
            period(1 << c);
        end
        apb(1'b1, 12'h008, 32'h5);
        rd(12'h008, 32'h4);
        apb(1'b1, 12'h004, 32'h4);
        repeat (10) @(posedge clk);
        check({src, periph_hs}, 32'h1, "periph on hs");
        apb(1'b1, 12'h004, 32'h5);
        repeat (10) @(posedge clk);
        check({src, periph_hs}, 32'h3, "main on hs");
        rd(12'h004, 32'h7);
        period(16);
        apb(1'b1, 12'h000, 32'h1);
        repeat (5) @(posedge clk);
        check(osc_run, 32'h0, "halt bit");
        rd(12'h000, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        repeat (20) @(posedge clk);
        check(osc_run, 32'h1, "restart");
        rd(12'h000, 32'h80);
        apb(1'b1, 12'h008, 32'h14);
        repeat (10) @(posedge clk);
        check(src, 32'h2, "cpu on sub");
        period(2);
        rd(12'h008, 32'h34);
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b1, 12'h004, 32'h0);
        repeat (10) @(posedge clk);
        check(src, 32'h0, "cpu on internal");
        stop_exec <= 1'b1;
        @(posedge clk);
        stop_exec <= 1'b0;
        repeat (5) @(posedge clk);
        check({stop_mode, osc_run}, 32'h2, "stop entered");
        rd(12'h000, 32'h0);
        stop_wake <= 1'b1;
        @(posedge clk);
        stop_wake <= 1'b0;
        repeat (20) @(posedge clk);
        check({stop_mode, osc_run}, 32'h1, "woken");
        rd(12'h000, 32'h80);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 12'h00C, pin_val[i]);
            repeat (3) @(posedge clk);
            check({pin_a, pin_ext, pin_b}, pin_exp[i], "pin mode");
            check(pin_b_oe, 32'h0, "pin b idle");
        end
        apb(1'b1, 12'h010, 32'h1);
        check(e, 32'h1, "unmapped write");
        apb(1'b0, 12'h010, 32'h0);
        check(e, 32'h1, "unmapped read err");
        check(r, 32'h0, "unmapped read data");
        tally_and_finish();
    end
endmodule // oscillator_clock_select_tb_top
